// ==== logic/ras_index_defines.svh ====
`ifndef RAS_INDEX_DEFINES_SVH
`define RAS_INDEX_DEFINES_SVH

// Encoding of the two index registers and the selected-record window
`define RAS_OP0 2'h3
`define RAS_OP1 3'h0
`define RAS_CRN 4'h5
`define RAS_CRM_INDEX 4'h3
`define RAS_CRM_WINDOW 4'h4
`define RAS_OP2_COUNT 3'h0
`define RAS_OP2_SELECT 3'h1
`define RAS_OP2_WIN_FIRST 3'h0
`define RAS_OP2_WIN_LAST 3'h6

// Field layout and values
`define RAS_FIELD_W 16
`define RAS_RECORD_COUNT 16'h0003
`define RAS_SELECT_RESET 16'h0000
`define RAS_REG_W 64
`define RAS_EC_W 6
`define RAS_EC_SYSREG 6'h18

// Exception level codes
`define RAS_EL0 2'h0
`define RAS_EL1 2'h1
`define RAS_EL2 2'h2
`define RAS_EL3 2'h3

`endif

// ==== logic/ras_index_pkg.sv ====
`include "ras_index_defines.svh"

package ras_index_pkg;

   // Outcome of one system-register access
   typedef enum logic [1:0] {
      RESP_DONE = 2'b00,
      RESP_UNDEF = 2'b01,
      RESP_TRAP = 2'b10
   } resp_kind_t;

   // Whole state of the access unit
   typedef struct packed {
      logic [`RAS_FIELD_W-1:0] select;
      logic resp_valid;
      resp_kind_t kind;
      logic [1:0] trap_el;
      logic [`RAS_REG_W-1:0] rdata;
   } unit_state_t;

endpackage

// ==== logic/ras_access_check.sv ====
`timescale 1ns/10ps
`default_nettype none

// Privilege and trap decision for one access; purely combinational
module ras_access_check
   import ras_index_pkg::*;
(
   input wire logic [1:0] current_exception_level,
   input wire logic halted,
   input wire logic secure_debug_disabled,
   input wire logic el2_enabled,
   input wire logic secure_error_reg_trap,
   input wire logic hyp_error_reg_trap,
   input wire logic fine_grain_trap_enable,
   input wire logic fine_trap_bit,
   output logic undefined,
   output logic trap,
   output logic [1:0] trap_el
);

   logic debug_locked;

   // Halted with secure debug off hides the trap to the secure monitor
   assign debug_locked = halted & secure_debug_disabled;

   // Checks in priority order, first match wins
   always_comb
   begin
      undefined = 1'b0;
      trap = 1'b0;
      trap_el = `RAS_EL3;
      case (current_exception_level)
         `RAS_EL0:
         begin
            undefined = 1'b1;
         end
         `RAS_EL1:
         begin
            if (debug_locked && secure_error_reg_trap)
            begin
               undefined = 1'b1;
            end
            else if (el2_enabled && hyp_error_reg_trap)
            begin
               trap = 1'b1;
               trap_el = `RAS_EL2;
            end
            else if (el2_enabled && fine_grain_trap_enable && fine_trap_bit)
            begin
               trap = 1'b1;
               trap_el = `RAS_EL2;
            end
            else if (secure_error_reg_trap)
            begin
               trap = 1'b1;
               trap_el = `RAS_EL3;
            end
         end
         `RAS_EL2:
         begin
            if (debug_locked && secure_error_reg_trap)
            begin
               undefined = 1'b1;
            end
            else if (secure_error_reg_trap)
            begin
               trap = 1'b1;
               trap_el = `RAS_EL3;
            end
         end
         default:
         begin
            undefined = 1'b0;
         end
      endcase
   end

endmodule // ras_access_check

`default_nettype wire

// ==== logic/ras_error_record_access.sv ====
`timescale 1ns/10ps
`default_nettype none


module ras_error_record_access
   import ras_index_pkg::*;
#(
   parameter logic [`RAS_FIELD_W-1:0] RECORD_COUNT = `RAS_RECORD_COUNT
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [1:0] req_op0,
   input wire logic [2:0] req_op1,
   input wire logic [3:0] req_crn,
   input wire logic [3:0] req_crm,
   input wire logic [2:0] req_op2,
   input wire logic [`RAS_REG_W-1:0] req_wdata,
   input wire logic [1:0] current_exception_level,
   input wire logic halted,
   input wire logic secure_debug_disabled,
   input wire logic el2_enabled,
   input wire logic secure_error_reg_trap,
   input wire logic hyp_error_reg_trap,
   input wire logic fine_grain_trap_enable,
   input wire logic hyp_fine_read_trap_count,
   input wire logic hyp_fine_read_trap_select,
   input wire logic hyp_fine_write_trap_select,
   input wire logic [`RAS_REG_W-1:0] window_rdata,
   output logic resp_valid,
   output logic resp_done,
   output logic resp_undefined,
   output logic resp_trap,
   output logic [1:0] resp_trap_el,
   output logic [`RAS_EC_W-1:0] resp_syndrome_class,
   output logic [`RAS_REG_W-1:0] resp_rdata,
   output logic [`RAS_FIELD_W-1:0] error_record_select,
   output logic window_valid,
   output logic window_write,
   output logic [2:0] window_op2,
   output logic [`RAS_FIELD_W-1:0] window_index,
   output logic [`RAS_REG_W-1:0] window_wdata
);

   localparam int UPPER_W = `RAS_REG_W - `RAS_FIELD_W;

   unit_state_t state_reg;
   unit_state_t state_next;

   logic in_group;
   logic hit_count;
   logic hit_select;
   logic hit_window;
   logic hit_any;
   logic bad_write;
   logic fine_trap_bit;
   logic chk_undefined;
   logic chk_trap;
   logic [1:0] chk_trap_el;
   logic granted;
   logic records_present;
   logic [`RAS_REG_W-1:0] error_record_count_reg;
   logic [`RAS_REG_W-1:0] error_record_select_reg;

   // Records exist only when the count is non-zero
   assign records_present = (RECORD_COUNT != `RAS_FIELD_W'(0));

   // Read views of the two registers, upper bits held at zero
   assign error_record_count_reg = {{UPPER_W{1'b0}}, RECORD_COUNT};
   assign error_record_select_reg = {{UPPER_W{1'b0}}, state_reg.select};

   // Common part of the encoding shared by all registers here
   assign in_group = (req_op0 == `RAS_OP0)
      && (req_op1 == `RAS_OP1)
      && (req_crn == `RAS_CRN);

   // Index register decode
   assign hit_count = in_group
      && (req_crm == `RAS_CRM_INDEX)
      && (req_op2 == `RAS_OP2_COUNT);
   assign hit_select = in_group
      && (req_crm == `RAS_CRM_INDEX)
      && (req_op2 == `RAS_OP2_SELECT);

   // Window decode covers record and pseudo-fault registers alike
   assign hit_window = in_group
      && (req_crm == `RAS_CRM_WINDOW)
      && (req_op2 >= `RAS_OP2_WIN_FIRST)
      && (req_op2 <= `RAS_OP2_WIN_LAST);

   assign hit_any = hit_count || hit_select || hit_window;

   // The count register has no write form; a write to it is undefined
   assign bad_write = req_write && hit_count;

   // Fine-grained trap bit that belongs to this access and direction
   always_comb
   begin
      fine_trap_bit = 1'b0;
      if (hit_count && !req_write)
      begin
         fine_trap_bit = hyp_fine_read_trap_count;
      end
      else if (hit_select && !req_write)
      begin
         fine_trap_bit = hyp_fine_read_trap_select;
      end
      else if (hit_select && req_write)
      begin
         fine_trap_bit = hyp_fine_write_trap_select;
      end
   end

   // Privilege and trap ladder
   ras_access_check u_check (
      .current_exception_level(current_exception_level),
      .halted(halted),
      .secure_debug_disabled(secure_debug_disabled),
      .el2_enabled(el2_enabled),
      .secure_error_reg_trap(secure_error_reg_trap),
      .hyp_error_reg_trap(hyp_error_reg_trap),
      .fine_grain_trap_enable(fine_grain_trap_enable),
      .fine_trap_bit(fine_trap_bit),
      .undefined(chk_undefined),
      .trap(chk_trap),
      .trap_el(chk_trap_el)
   );

   // An access completes only when decoded and neither refused nor trapped
   assign granted = req_valid && hit_any && !bad_write && !chk_undefined && !chk_trap;

   // Window strobe to the record store; it answers in the same cycle
   assign window_valid = granted && hit_window;
   assign window_write = req_write;
   assign window_op2 = req_op2;
   assign window_index = state_reg.select;
   assign window_wdata = req_wdata;

   // Next-state logic for the select field and the registered answer
   always_comb
   begin
      state_next = state_reg;
      state_next.resp_valid = req_valid;
      if (req_valid)
      begin
         state_next.rdata = '0;
         state_next.trap_el = `RAS_EL3;
         if (!hit_any || bad_write)
         begin
            // Unclaimed encodings behave as undefined instructions
            state_next.kind = RESP_UNDEF;
         end
         else if (chk_undefined)
         begin
            state_next.kind = RESP_UNDEF;
         end
         else if (chk_trap)
         begin
            state_next.kind = RESP_TRAP;
            state_next.trap_el = chk_trap_el;
         end
         else
         begin
            state_next.kind = RESP_DONE;
            if (hit_count)
            begin
               state_next.rdata = error_record_count_reg;
            end
            else if (hit_select && !req_write)
            begin
               state_next.rdata = error_record_select_reg;
            end
            else if (hit_window && !req_write)
            begin
               state_next.rdata = window_rdata;
            end
            // Writes keep only the low field; the rest is ignored
            if (hit_select && req_write && records_present)
            begin
               state_next.select = req_wdata[`RAS_FIELD_W-1:0];
            end
         end
      end
      // With no records the select field is held at zero
      if (!records_present)
      begin
         state_next.select = '0;
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg.select <= `RAS_SELECT_RESET;
         state_reg.resp_valid <= 1'b0;
         state_reg.kind <= RESP_DONE;
         state_reg.trap_el <= `RAS_EL3;
         state_reg.rdata <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Answer outputs are all decoded from the registered state
   assign resp_valid = state_reg.resp_valid;
   assign resp_done = state_reg.resp_valid && (state_reg.kind == RESP_DONE);
   assign resp_undefined = state_reg.resp_valid && (state_reg.kind == RESP_UNDEF);
   assign resp_trap = state_reg.resp_valid && (state_reg.kind == RESP_TRAP);
   assign resp_trap_el = state_reg.trap_el;
   // Class stands only with a trap so a stale value is never seen
   assign resp_syndrome_class = resp_trap ? `RAS_EC_SYSREG : `RAS_EC_W'(0);
   assign resp_rdata = state_reg.rdata;
   assign error_record_select = state_reg.select;

endmodule // ras_error_record_access

`default_nettype wire

// ==== sim/ras_access_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the access unit
module ras_access_asserts
   import ras_index_pkg::*;
#(
   parameter logic [15:0] RECORD_COUNT = 16'h0003
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [1:0] req_op0,
   input wire logic [2:0] req_op1,
   input wire logic [3:0] req_crn,
   input wire logic [3:0] req_crm,
   input wire logic [2:0] req_op2,
   input wire logic [1:0] current_exception_level,
   input wire logic halted,
   input wire logic secure_debug_disabled,
   input wire logic el2_enabled,
   input wire logic secure_error_reg_trap,
   input wire logic hyp_error_reg_trap,
   input wire logic resp_valid,
   input wire logic resp_done,
   input wire logic resp_undefined,
   input wire logic resp_trap,
   input wire logic [1:0] resp_trap_el,
   input wire logic [5:0] resp_syndrome_class,
   input wire logic [63:0] resp_rdata,
   input wire logic [15:0] error_record_select,
   input wire logic window_valid,
   input wire logic [15:0] window_index
);
   logic idx;
   logic lock;
   logic [1:0] el;
   // Index register hit and debug lockout terms
   assign idx = req_valid && req_op0 == 2'h3 && req_op1 == 3'h0 && req_crn == 4'h5 && req_crm == 4'h3;
   assign lock = halted && secure_debug_disabled && secure_error_reg_trap;
   assign el = current_exception_level;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_lat; req_valid |=> resp_valid && $onehot({resp_done, resp_undefined, resp_trap}); endproperty
   a_lat: assert property (p_lat) else $error("response missing or not one-hot");
   property p_el0; req_valid && el == 2'h0 |=> resp_undefined; endproperty
   a_el0: assert property (p_el0) else $error("EL0 access not undefined");
   property p_lock; req_valid && (el == 2'h1 || el == 2'h2) && lock |=> resp_undefined; endproperty
   a_lock: assert property (p_lock) else $error("locked access not undefined");
   property p_hyp; idx && req_op2 == 3'h1 && el == 2'h1 && !lock && el2_enabled && hyp_error_reg_trap
      |=> resp_trap && resp_trap_el == 2'h2; endproperty
   a_hyp: assert property (p_hyp) else $error("hypervisor trap missing");
   property p_sec; idx && req_op2 == 3'h1 && el == 2'h2 && secure_error_reg_trap && !lock
      |=> resp_trap && resp_trap_el == 2'h3; endproperty
   a_sec: assert property (p_sec) else $error("secure trap missing");
   property p_class; resp_valid |-> resp_syndrome_class == (resp_trap ? 6'h18 : 6'h00); endproperty
   a_class: assert property (p_class) else $error("wrong syndrome class");
   property p_count; idx && !req_write && req_op2 == 3'h0 && el == 2'h3
      |=> resp_done && resp_rdata == {48'h0, RECORD_COUNT}; endproperty
   a_count: assert property (p_count) else $error("wrong record count");
   property p_sel; !$stable(error_record_select) |-> $past(req_valid) && $past(req_write) && resp_done;
   endproperty
   a_sel: assert property (p_sel) else $error("select changed without a granted write");
   property p_idx; window_valid |-> window_index == error_record_select && req_crm == 4'h4; endproperty
   a_idx: assert property (p_idx) else $error("window index not the select field");
endmodule // ras_access_asserts
bind ras_error_record_access ras_access_asserts #(.RECORD_COUNT(RECORD_COUNT)) chk (.*);
`default_nettype wire

// ==== sim/ras_error_record_access_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module ras_error_record_access_bench;
   import ras_index_pkg::*;
   logic core_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   logic [3:0] req_crm = 4'h3;
   logic [3:0] req_crn = 4'h5;
   logic [2:0] req_op1 = 3'h0;
   logic [2:0] req_op2 = 3'h0;
   logic [63:0] req_wdata = 64'h0;
   logic [1:0] current_exception_level = 2'h3;
   logic [7:0] ctl = 8'h00;
   logic resp_valid, resp_done, resp_undefined, resp_trap, window_valid, window_write;
   logic [1:0] resp_trap_el;
   logic [5:0] resp_syndrome_class;
   logic [63:0] resp_rdata, window_wdata;
   logic [15:0] error_record_select, window_index;
   logic [2:0] window_op2;
   int miscompares = 0, n_checks = 0;
   // Fixed record-store data; the window only needs to pass it through
   localparam logic [63:0] WIN = 64'h0123_4567_89ab_cdef;
   ras_error_record_access dut (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
      .req_write(req_write), .req_op0(2'h3), .req_op1(req_op1), .req_crn(req_crn), .req_crm(req_crm),
      .req_op2(req_op2), .req_wdata(req_wdata), .current_exception_level(current_exception_level),
      .halted(ctl[7]), .secure_debug_disabled(ctl[6]), .el2_enabled(ctl[5]),
      .secure_error_reg_trap(ctl[4]), .hyp_error_reg_trap(ctl[3]), .fine_grain_trap_enable(ctl[2]),
      .hyp_fine_read_trap_count(ctl[1]), .hyp_fine_read_trap_select(ctl[1]),
      .hyp_fine_write_trap_select(ctl[0]), .window_rdata(WIN), .resp_valid(resp_valid),
      .resp_done(resp_done), .resp_undefined(resp_undefined), .resp_trap(resp_trap),
      .resp_trap_el(resp_trap_el), .resp_syndrome_class(resp_syndrome_class),
      .resp_rdata(resp_rdata), .error_record_select(error_record_select),
      .window_valid(window_valid), .window_write(window_write), .window_op2(window_op2),
      .window_index(window_index), .window_wdata(window_wdata));
   initial forever #10 core_clk = ~core_clk;
   task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One access; k is 0 done, 1 undefined, 2 trap; answer checked one cycle later
   task acc(input logic w, input logic [3:0] crm, input logic [2:0] op2, input logic [63:0] wd,
      input logic [1:0] el, input logic [7:0] c, input logic [1:0] k, input logic [1:0] tel,
      input logic [63:0] rd);
      @(negedge core_clk);
      req_valid = 1'b1;
      req_write = w;
      req_crm = crm;
      req_op2 = op2;
      req_wdata = wd;
      current_exception_level = el;
      ctl = c;
      #1 chk("window_valid", window_valid, crm == 4'h4 && k == 2'h0);
      @(negedge core_clk);
      req_valid = 1'b0;
      chk("resp_valid", resp_valid, 1'b1);
      chk("kind", {resp_done, resp_undefined, resp_trap}, k == 0 ? 3'h4 : k == 1 ? 3'h2 : 3'h1);
      chk("trap_el", resp_trap_el, tel);
      chk("class", resp_syndrome_class, k == 2 ? 6'h18 : 6'h00);
      chk("rdata", resp_rdata, rd);
   endtask
   task results;
      if (miscompares == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Watchdog, far beyond the roughly 1.2 microseconds the sequence needs
   initial
   begin
      #20000;
      miscompares++;
      results;
   end
   // Main sequence: index registers, window, then every step of the check ladder
   initial
   begin
      repeat (5) @(negedge core_clk);
      rstn = 1'b1;
      chk("select", error_record_select, 16'h0);
      acc(0, 3, 0, 0, 3, 0, 0, 3, 64'h3);
      acc(1, 3, 0, 0, 3, 0, 1, 3, 0);
      acc(1, 3, 1, 64'hffff_ffff_ffff_0001, 3, 0, 0, 3, 0);
      chk("select", error_record_select, 16'h1);
      chk("index", window_index, 16'h1);
      acc(0, 3, 1, 0, 3, 0, 0, 3, 64'h1);
      for (int i = 0; i < 7; i++) acc(i[0], 4, i[2:0], 0, 3, 0, 0, 3, i[0] ? 64'h0 : WIN);
      acc(0, 3, 0, 0, 0, 0, 1, 3, 0);
      acc(1, 3, 1, 0, 0, 0, 1, 3, 0);
      acc(0, 3, 1, 0, 1, 8'hd8, 1, 3, 0);
      acc(1, 3, 1, 0, 2, 8'hd0, 1, 3, 0);
      acc(0, 3, 0, 0, 1, 8'h28, 2, 2, 0);
      acc(0, 3, 0, 0, 1, 8'h08, 0, 3, 64'h3);
      acc(0, 3, 0, 0, 1, 8'h26, 2, 2, 0);
      acc(1, 3, 1, 64'h2, 1, 8'h25, 2, 2, 0);
      acc(1, 3, 1, 64'h2, 1, 8'h26, 0, 3, 0);
      acc(1, 3, 1, 64'h5, 1, 8'h10, 2, 3, 0);
      acc(0, 3, 1, 0, 2, 8'h18, 2, 3, 0);
      acc(0, 3, 1, 0, 2, 8'hc8, 0, 3, 64'h2);
      acc(0, 3, 1, 0, 3, 8'hff, 0, 3, 64'h2);
      acc(0, 5, 0, 0, 3, 0, 1, 3, 0);
      // Wrong CRn or op1 must not reach either index register
      req_crn = 4'h6;
      acc(0, 3, 0, 0, 3, 0, 1, 3, 0);
      req_crn = 4'h5;
      req_op1 = 3'h1;
      acc(0, 3, 1, 0, 3, 0, 1, 3, 0);
      req_op1 = 3'h0;
      chk("select", error_record_select, 16'h2);
      @(negedge core_clk);
      rstn = 1'b0;
      @(negedge core_clk);
      rstn = 1'b1;
      chk("select", error_record_select, 16'h0);
      results;
   end
endmodule // ras_error_record_access_bench
`default_nettype wire
